// ### dv/fcd_top_sva.sv
`timescale 1ns/1ns
module fcd_top_sva (
    // Clock, reset and stimulus
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic mode_special_i,
    input wire logic [7:0] command_code_i,
    input wire logic target_dflash_i,
    input wire logic launch_i,
    input wire logic pflash_low_unprotect_i,
    input wire logic pflash_high_unprotect_i,
    input wire logic pflash_protect_open_i,
    input wire logic dflash_protect_open_i,
    input wire logic op_done_i,
    input wire logic verify_ok_i,
    // Design outputs
    input wire logic command_complete_flag_o,
    input wire logic access_error_flag_o,
    input wire logic protect_violation_flag_o,
    input wire logic divider_loaded_flag_o,
    input wire logic security_release_o,
    input wire logic op_start_o,
    input wire logic [7:0] op_code_o,
    input wire logic pflash_read_ok_o
);
    // ****************************************************************
    // Accepted launch and protection summary
    // ****************************************************************
    wire logic take = launch_i && command_complete_flag_o && !access_error_flag_o
        && !protect_violation_flag_o;
    wire logic pf_open = pflash_low_unprotect_i && pflash_high_unprotect_i
        && pflash_protect_open_i;
    wire logic nm_ld = take && !mode_special_i && divider_loaded_flag_o;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // ****************************************************************
    // Checks
    // ****************************************************************
    unknown_code_a: assert property (take && !(command_code_i inside {8'h01, 8'h02,
        8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
        8'h10, 8'h11, 8'h12}) |=> access_error_flag_o && !op_start_o)
        else $error("unknown code not refused");
    no_divider_a: assert property (take && !divider_loaded_flag_o
        && command_code_i == 8'h06 |=> access_error_flag_o && !op_start_o)
        else $error("program ran before divider load");
    erase_all_a: assert property (take && mode_special_i && divider_loaded_flag_o
        && command_code_i == 8'h08 && !(pf_open && dflash_protect_open_i)
        |=> protect_violation_flag_o && !op_start_o) else $error("erase all not guarded");
    pblock_a: assert property (nm_ld && command_code_i == 8'h09 && !target_dflash_i
        && !pf_open |=> protect_violation_flag_o) else $error("pflash block erase unguarded");
    dblock_a: assert property (nm_ld && command_code_i == 8'h09 && target_dflash_i
        && !dflash_protect_open_i |=> protect_violation_flag_o)
        else $error("dflash block erase unguarded");
    field_normal_a: assert property (take && !mode_special_i
        && command_code_i == 8'h0e |=> access_error_flag_o) else $error("field margin in normal");
    margin_local_a: assert property (take && !mode_special_i && command_code_i == 8'h0d
        |=> !command_complete_flag_o && !op_start_o ##1 command_complete_flag_o)
        else $error("user margin not one cycle local");
    dispatch_a: assert property (nm_ld && command_code_i == 8'h06
        |=> op_start_o && op_code_o == 8'h06 && !command_complete_flag_o)
        else $error("program not dispatched");
    done_return_a: assert property (!command_complete_flag_o && op_done_i
        && op_code_o != 8'h08 |=> command_complete_flag_o) else $error("complete not restored");
    pread_block_a: assert property (op_start_o && op_code_o == 8'h06 |-> !pflash_read_ok_o)
        else $error("pflash read during pflash program");
    release_cause_a: assert property (security_release_o |-> $past(op_done_i && verify_ok_i))
        else $error("security released without good verify");
endmodule : fcd_top_sva

bind fcd_top fcd_top_sva sva (.sys_clk_i, .rst_b_i, .mode_special_i, .command_code_i,
    .target_dflash_i, .launch_i, .pflash_low_unprotect_i, .pflash_high_unprotect_i,
    .pflash_protect_open_i, .dflash_protect_open_i, .op_done_i, .verify_ok_i,
    .command_complete_flag_o, .access_error_flag_o, .protect_violation_flag_o,
    .divider_loaded_flag_o, .security_release_o, .op_start_o, .op_code_o, .pflash_read_ok_o);

// ### dv/test_fcd_top.sv
`timescale 1ns/1ns
module test_fcd_top;
    // ****************************************************************
    // Stimulus, observation and counters
    // ****************************************************************
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, mode_special_i = 1'b0, secured_i = 1'b0;
    logic [7:0] command_code_i = 8'h00;
    logic [2:0] word_count_i = 3'h1;
    logic [fcd_pkg::MARGIN_W-1:0] margin_level_i = 2'h0;
    logic target_dflash_i = 1'b0, launch_i = 1'b0, error_clear_i = 1'b0;
    logic divider_write_i = 1'b0, once_field_used_i = 1'b0, op_done_i = 1'b0;
    logic pflash_low_unprotect_i = 1'b0, pflash_high_unprotect_i = 1'b0, verify_ok_i = 1'b1;
    logic pflash_protect_open_i = 1'b0, dflash_protect_open_i = 1'b0;
    logic command_complete_flag_o, access_error_flag_o, protect_violation_flag_o;
    logic divider_loaded_flag_o, security_release_o, op_start_o, op_target_dflash_o;
    logic pflash_read_ok_o, dflash_read_ok_o;
    logic [7:0] op_code_o;
    logic [2:0] op_word_count_o;
    logic [fcd_pkg::MARGIN_W-1:0] pflash_user_margin_o, dflash_user_margin_o;
    logic [fcd_pkg::MARGIN_W-1:0] pflash_field_margin_o, dflash_field_margin_o;
    int miscompares = 0, samples_checked = 0, eng_cnt = 0, rel_cnt = 0;

    fcd_top dut (.sys_clk_i, .rst_b_i, .mode_special_i, .secured_i, .command_code_i,
        .target_dflash_i, .word_count_i, .margin_level_i, .launch_i, .error_clear_i,
        .divider_write_i, .pflash_low_unprotect_i, .pflash_high_unprotect_i,
        .pflash_protect_open_i, .dflash_protect_open_i, .once_field_used_i, .op_done_i,
        .verify_ok_i, .command_complete_flag_o, .access_error_flag_o,
        .protect_violation_flag_o, .divider_loaded_flag_o, .security_release_o, .op_start_o,
        .op_code_o, .op_target_dflash_o, .op_word_count_o, .pflash_read_ok_o,
        .dflash_read_ok_o, .pflash_user_margin_o, .dflash_user_margin_o,
        .pflash_field_margin_o, .dflash_field_margin_o);

    // Clock
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // Array engine stand-in: done four cycles after start, counts releases
    always @(posedge sys_clk_i) begin
        #1;
        op_done_i = (eng_cnt == 1);
        if (op_start_o === 1'b1) eng_cnt = 4;
        else if (eng_cnt > 0) eng_cnt--;
        if (security_release_o === 1'b1) rel_cnt++;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic tick;
        @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    // Protect bits as low, high, open, dflash open
    task automatic prot(input logic [3:0] b);
        {pflash_low_unprotect_i, pflash_high_unprotect_i} = b[3:2];
        {pflash_protect_open_i, dflash_protect_open_i} = b[1:0];
    endtask : prot

    // Kind 0 dispatch, 1 local, 2 access error, 3 protect violation
    task automatic run(input logic [7:0] code, input logic td, input logic [2:0] wc,
        input int kind);
        int n;
        command_code_i = code;
        target_dflash_i = td;
        word_count_i = wc;
        launch_i = 1'b1;
        tick();
        launch_i = 1'b0;
        chk({access_error_flag_o, protect_violation_flag_o}, {kind == 2, kind == 3});
        chk({op_start_o, command_complete_flag_o}, {kind == 0, kind >= 2});
        if (kind == 0) chk(op_code_o, (code == 8'h0b) ? 8'h08 : code);
        if (kind == 0) chk({op_target_dflash_o, op_word_count_o}, {td, wc});
        if (kind == 0 && code == 8'h06) chk(pflash_read_ok_o, 1'b0);
        if (kind == 0 && code == 8'h06) chk(dflash_read_ok_o, 1'b0);
        if (kind == 0 && code == 8'h11) chk(pflash_read_ok_o, 1'b1);
        error_clear_i = (kind >= 2);
        tick();
        error_clear_i = 1'b0;
        for (n = 0; command_complete_flag_o !== 1'b1; n++) begin
            if (n > 40) begin
                miscompares++;
                end_sim();
            end
            tick();
        end
        chk({access_error_flag_o, protect_violation_flag_o, pflash_read_ok_o}, 3'h1);
    endtask : run

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic s_divider;
        chk({command_complete_flag_o, access_error_flag_o, divider_loaded_flag_o}, 3'h4);
        run(8'h06, 1'b0, 3'h1, 2);
        divider_write_i = 1'b1;
        tick();
        divider_write_i = 1'b0;
        chk(divider_loaded_flag_o, 1'b1);
        run(8'h06, 1'b0, 3'h1, 0);
    endtask : s_divider

    task automatic s_codes;
        logic [7:0] bad [4] = '{8'h05, 8'h0f, 8'h13, 8'hff};
        logic [7:0] good [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0a, 8'h11, 8'h12, 8'h09};
        int r;
        foreach (bad[i]) run(bad[i], 1'b0, 3'h1, 2);
        prot(4'hf);
        foreach (good[i]) run(good[i], 1'b0, 3'h4, 0);
        run(8'h09, 1'b1, 3'h1, 0);
        r = rel_cnt;
        run(8'h0c, 1'b0, 3'h1, 0);
        tick();
        chk(8'(rel_cnt - r), 8'h01);
        // A failed key check must not release security
        verify_ok_i = 1'b0;
        run(8'h0c, 1'b0, 3'h1, 0);
        tick();
        chk(8'(rel_cnt - r), 8'h01);
        verify_ok_i = 1'b1;
    endtask : s_codes

    task automatic s_protect;
        prot(4'h7);
        run(8'h09, 1'b0, 3'h1, 3);
        prot(4'he);
        run(8'h09, 1'b1, 3'h1, 3);
        run(8'h09, 1'b0, 3'h1, 0);
        mode_special_i = 1'b1;
        run(8'h08, 1'b0, 3'h1, 3);
        prot(4'hf);
        run(8'h08, 1'b0, 3'h1, 0);
        mode_special_i = 1'b0;
    endtask : s_protect

    task automatic s_limits;
        run(8'h11, 1'b0, 3'h0, 2);
        run(8'h11, 1'b0, 3'h5, 2);
        once_field_used_i = 1'b1;
        run(8'h07, 1'b0, 3'h1, 2);
        once_field_used_i = 1'b0;
        run(8'h07, 1'b0, 3'h1, 0);
        run(8'h07, 1'b0, 3'h1, 2);
    endtask : s_limits

    task automatic s_modes;
        int r;
        run(8'h0e, 1'b0, 3'h1, 2);
        margin_level_i = 2'h2;
        run(8'h0d, 1'b1, 3'h1, 1);
        chk({dflash_user_margin_o, pflash_user_margin_o}, 4'h8);
        mode_special_i = 1'b1;
        margin_level_i = 2'h1;
        run(8'h0e, 1'b0, 3'h1, 1);
        chk({pflash_field_margin_o, dflash_field_margin_o}, 4'h4);
        run(8'h0c, 1'b0, 3'h1, 2);
        r = rel_cnt;
        run(8'h0b, 1'b0, 3'h1, 0);
        tick();
        chk(op_code_o, 8'h01);
        chk(8'(rel_cnt - r), 8'h01);
        secured_i = 1'b1;
        run(8'h06, 1'b0, 3'h1, 2);
        run(8'h01, 1'b0, 3'h1, 0);
    endtask : s_modes

    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk_i);
        #1 rst_b_i = 1'b1;
        repeat (3) tick();
        s_divider();
        s_codes();
        s_protect();
        s_limits();
        s_modes();
        end_sim();
    end
endmodule : test_fcd_top

// ### rtl/fcd_dec_if.sv
`timescale 1ns/1ns
interface fcd_dec_if;
    logic [7:0] code;
    logic special;
    logic secured;
    logic target_df;
    fcd_pkg::fcd_class_s cls;

    // ****************************************************************
    // Sequencer side and decoder side
    // ****************************************************************
    modport seq (output code, output special, output secured, output target_df, input cls);
    modport dec (input code, input special, input secured, input target_df, output cls);
endinterface : fcd_dec_if

// ### rtl/fcd_decode.sv
`timescale 1ns/1ns
module fcd_decode (
    // Command to classify
    fcd_dec_if.dec dec
);

    // ****************************************************************
    // Availability per mode and security
    // ****************************************************************
    function automatic logic fcd_avail(input logic [7:0] c, input logic sp, input logic sec);
        logic known;
        logic ok;
        known = 1'b1;
        case (c)
            fcd_pkg::CMD_VERIFY_ALL, fcd_pkg::CMD_VERIFY_BLOCK: ok = 1'b1;
            fcd_pkg::CMD_ERASE_ALL, fcd_pkg::CMD_UNSECURE: ok = sp;
            fcd_pkg::CMD_KEY_VERIFY: ok = !sp;
            fcd_pkg::CMD_FIELD_MARGIN: ok = sp && !sec;
            fcd_pkg::CMD_VERIFY_PSECT, fcd_pkg::CMD_READ_ONCE, fcd_pkg::CMD_PROG_P,
            fcd_pkg::CMD_PROG_ONCE, fcd_pkg::CMD_ERASE_BLOCK, fcd_pkg::CMD_ERASE_PSECT,
            fcd_pkg::CMD_USER_MARGIN, fcd_pkg::CMD_VERIFY_DSECT, fcd_pkg::CMD_PROG_D,
            fcd_pkg::CMD_ERASE_DSECT: ok = !(sec && sp);
            default: begin
                known = 1'b0;
                ok = 1'b0;
            end
        endcase
        return known && ok;
    endfunction : fcd_avail

    // ****************************************************************
    // Command class
    // ****************************************************************
    always_comb begin
        dec.cls = '0;
        dec.cls.valid = fcd_avail(dec.code, dec.special, dec.secured);
        case (dec.code)
            fcd_pkg::CMD_VERIFY_ALL: begin
                dec.cls.uses_pf = 1'b1;
                dec.cls.uses_df = 1'b1;
            end
            fcd_pkg::CMD_VERIFY_BLOCK: begin
                dec.cls.uses_pf = !dec.target_df;
                dec.cls.uses_df = dec.target_df;
            end
            fcd_pkg::CMD_VERIFY_PSECT, fcd_pkg::CMD_READ_ONCE,
            fcd_pkg::CMD_KEY_VERIFY: dec.cls.uses_pf = 1'b1;
            fcd_pkg::CMD_PROG_P, fcd_pkg::CMD_PROG_ONCE, fcd_pkg::CMD_ERASE_PSECT: begin
                dec.cls.pgm_erase = 1'b1;
                dec.cls.uses_pf = 1'b1;
            end
            fcd_pkg::CMD_ERASE_ALL, fcd_pkg::CMD_UNSECURE: begin
                dec.cls.pgm_erase = 1'b1;
                dec.cls.uses_pf = 1'b1;
                dec.cls.uses_df = 1'b1;
            end
            fcd_pkg::CMD_ERASE_BLOCK: begin
                dec.cls.pgm_erase = 1'b1;
                dec.cls.uses_pf = !dec.target_df;
                dec.cls.uses_df = dec.target_df;
            end
            fcd_pkg::CMD_VERIFY_DSECT: dec.cls.uses_df = 1'b1;
            fcd_pkg::CMD_PROG_D, fcd_pkg::CMD_ERASE_DSECT: begin
                dec.cls.pgm_erase = 1'b1;
                dec.cls.uses_df = 1'b1;
            end
            fcd_pkg::CMD_USER_MARGIN, fcd_pkg::CMD_FIELD_MARGIN: dec.cls.margin = 1'b1;
            default: dec.cls.valid = 1'b0;
        endcase
    end

endmodule : fcd_decode

// ### rtl/fcd_pkg.sv
package fcd_pkg;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
    localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
    localparam logic [7:0] CMD_VERIFY_PSECT = 8'h03;
    localparam logic [7:0] CMD_READ_ONCE = 8'h04;
    localparam logic [7:0] CMD_PROG_P = 8'h06;
    localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
    localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
    localparam logic [7:0] CMD_ERASE_PSECT = 8'h0a;
    localparam logic [7:0] CMD_UNSECURE = 8'h0b;
    localparam logic [7:0] CMD_KEY_VERIFY = 8'h0c;
    localparam logic [7:0] CMD_USER_MARGIN = 8'h0d;
    localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
    localparam logic [7:0] CMD_VERIFY_DSECT = 8'h10;
    localparam logic [7:0] CMD_PROG_D = 8'h11;
    localparam logic [7:0] CMD_ERASE_DSECT = 8'h12;

    // ****************************************************************
    // Modes, sizes and reset values
    // ****************************************************************
    localparam logic MODE_NORMAL = 1'b0;
    localparam logic MODE_SPECIAL = 1'b1;
    localparam int ONCE_FIELD_BYTES = 64;
    localparam logic [2:0] PROG_D_MIN_WORDS = 3'h1;
    localparam logic [2:0] PROG_D_MAX_WORDS = 3'h4;
    localparam int MARGIN_W = 2;
    localparam logic [MARGIN_W-1:0] MARGIN_NORMAL = 2'h0;
    localparam logic COMPLETE_RST = 1'b1;
    localparam logic FLAG_RST = 1'b0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        FCD_IDLE,
        FCD_LOCAL,
        FCD_RUN,
        FCD_UNSEC_ERASE,
        FCD_UNSEC_VERIFY
    } fcd_state_e;

    typedef struct packed {
        logic valid;
        logic pgm_erase;
        logic uses_pf;
        logic uses_df;
        logic margin;
    } fcd_class_s;

endpackage : fcd_pkg

// ### rtl/fcd_top.sv
`timescale 1ns/1ns
module fcd_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Mode and security
    input wire logic mode_special_i,
    input wire logic secured_i,
    // Command write sequence
    input wire logic [7:0] command_code_i,
    input wire logic target_dflash_i,
    input wire logic [2:0] word_count_i,
    input wire logic [fcd_pkg::MARGIN_W-1:0] margin_level_i,
    input wire logic launch_i,
    input wire logic error_clear_i,
    // Clock divider write strobe
    input wire logic divider_write_i,
    // Protection bits
    input wire logic pflash_low_unprotect_i,
    input wire logic pflash_high_unprotect_i,
    input wire logic pflash_protect_open_i,
    input wire logic dflash_protect_open_i,
    // One-time field state held in the information area
    input wire logic once_field_used_i,
    // Array engine
    input wire logic op_done_i,
    input wire logic verify_ok_i,
    // Status
    output logic command_complete_flag_o,
    output logic access_error_flag_o,
    output logic protect_violation_flag_o,
    output logic divider_loaded_flag_o,
    output logic security_release_o,
    // Engine dispatch
    output logic op_start_o,
    output logic [7:0] op_code_o,
    output logic op_target_dflash_o,
    output logic [2:0] op_word_count_o,
    // Read permission and margin levels
    output logic pflash_read_ok_o,
    output logic dflash_read_ok_o,
    output logic [fcd_pkg::MARGIN_W-1:0] pflash_user_margin_o,
    output logic [fcd_pkg::MARGIN_W-1:0] dflash_user_margin_o,
    output logic [fcd_pkg::MARGIN_W-1:0] pflash_field_margin_o,
    output logic [fcd_pkg::MARGIN_W-1:0] dflash_field_margin_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        fcd_pkg::fcd_state_e state;
        logic command_complete_flag;
        logic access_error_flag;
        logic fpviol;
        logic div_loaded;
        logic once_done;
        logic sec_release;
        logic op_start;
        logic [7:0] code;
        logic target_df;
        logic [2:0] words;
        logic pf_busy;
        logic df_write;
        logic [fcd_pkg::MARGIN_W-1:0] pf_user;
        logic [fcd_pkg::MARGIN_W-1:0] df_user;
        logic [fcd_pkg::MARGIN_W-1:0] pf_field;
        logic [fcd_pkg::MARGIN_W-1:0] df_field;
    } fcd_regs_s;

    fcd_regs_s s;
    fcd_regs_s next_s;
    logic [1:0] rst_sync;
    logic rst_n;
    logic launch_ok;
    logic pf_open_all;
    fcd_dec_if dif ();

    // ****************************************************************
    // Reset release
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ****************************************************************
    // Command decode
    // ****************************************************************
    assign dif.code = command_code_i;
    assign dif.special = (mode_special_i == fcd_pkg::MODE_SPECIAL);
    assign dif.secured = secured_i;
    assign dif.target_df = target_dflash_i;

    fcd_decode u_decode (
        .dec(dif)
    );

    // Launch only taken while idle and no error pending
    assign launch_ok = launch_i && s.command_complete_flag && !s.access_error_flag && !s.fpviol;
    assign pf_open_all = pflash_low_unprotect_i && pflash_high_unprotect_i
        && pflash_protect_open_i;

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.op_start = 1'b0;
        next_s.sec_release = 1'b0;
        // Error clear first, so a same-cycle set below wins
        if (error_clear_i) begin
            next_s.access_error_flag = 1'b0;
            next_s.fpviol = 1'b0;
        end
        if (divider_write_i) begin
            next_s.div_loaded = 1'b1;
        end
        case (s.state)
            fcd_pkg::FCD_IDLE: begin
                if (launch_ok) begin
                    if (!dif.cls.valid) begin
                        next_s.access_error_flag = 1'b1;
                    end else if (dif.cls.pgm_erase && !s.div_loaded) begin
                        next_s.access_error_flag = 1'b1;
                    end else if (command_code_i == fcd_pkg::CMD_PROG_D
                            && (word_count_i < fcd_pkg::PROG_D_MIN_WORDS
                            || word_count_i > fcd_pkg::PROG_D_MAX_WORDS)) begin
                        next_s.access_error_flag = 1'b1;
                    end else if (command_code_i == fcd_pkg::CMD_PROG_ONCE
                            && (s.once_done || once_field_used_i)) begin
                        next_s.access_error_flag = 1'b1;
                    end else if (command_code_i == fcd_pkg::CMD_ERASE_ALL
                            && !(pf_open_all && dflash_protect_open_i)) begin
                        next_s.fpviol = 1'b1;
                    end else if (command_code_i == fcd_pkg::CMD_ERASE_BLOCK
                            && !target_dflash_i && !pf_open_all) begin
                        next_s.fpviol = 1'b1;
                    end else if (command_code_i == fcd_pkg::CMD_ERASE_BLOCK
                            && target_dflash_i && !dflash_protect_open_i) begin
                        next_s.fpviol = 1'b1;
                    end else if (dif.cls.margin) begin
                        // Margin levels are held here; done one cycle later
                        next_s.command_complete_flag = 1'b0;
                        next_s.state = fcd_pkg::FCD_LOCAL;
                        if (command_code_i == fcd_pkg::CMD_USER_MARGIN) begin
                            if (target_dflash_i) begin
                                next_s.df_user = margin_level_i;
                            end else begin
                                next_s.pf_user = margin_level_i;
                            end
                        end else if (target_dflash_i) begin
                            next_s.df_field = margin_level_i;
                        end else begin
                            next_s.pf_field = margin_level_i;
                        end
                    end else begin
                        // Dispatch to the array engine
                        next_s.command_complete_flag = 1'b0;
                        next_s.op_start = 1'b1;
                        next_s.code = command_code_i;
                        next_s.target_df = target_dflash_i;
                        next_s.words = word_count_i;
                        next_s.pf_busy = dif.cls.uses_pf;
                        next_s.df_write = dif.cls.uses_df && dif.cls.pgm_erase;
                        if (command_code_i == fcd_pkg::CMD_UNSECURE) begin
                            next_s.code = fcd_pkg::CMD_ERASE_ALL;
                            next_s.state = fcd_pkg::FCD_UNSEC_ERASE;
                        end else begin
                            next_s.state = fcd_pkg::FCD_RUN;
                        end
                    end
                end
            end
            fcd_pkg::FCD_LOCAL: begin
                next_s.command_complete_flag = 1'b1;
                next_s.state = fcd_pkg::FCD_IDLE;
            end
            fcd_pkg::FCD_RUN: begin
                if (op_done_i) begin
                    next_s.command_complete_flag = 1'b1;
                    next_s.pf_busy = 1'b0;
                    next_s.df_write = 1'b0;
                    next_s.state = fcd_pkg::FCD_IDLE;
                    if (s.code == fcd_pkg::CMD_PROG_ONCE) begin
                        next_s.once_done = 1'b1;
                    end
                    if (s.code == fcd_pkg::CMD_KEY_VERIFY && verify_ok_i) begin
                        next_s.sec_release = 1'b1;
                    end
                end
            end
            fcd_pkg::FCD_UNSEC_ERASE: begin
                // Erase done, now verify every block
                if (op_done_i) begin
                    next_s.op_start = 1'b1;
                    next_s.code = fcd_pkg::CMD_VERIFY_ALL;
                    next_s.df_write = 1'b0;
                    next_s.state = fcd_pkg::FCD_UNSEC_VERIFY;
                end
            end
            fcd_pkg::FCD_UNSEC_VERIFY: begin
                if (op_done_i) begin
                    next_s.command_complete_flag = 1'b1;
                    next_s.pf_busy = 1'b0;
                    next_s.sec_release = verify_ok_i;
                    next_s.state = fcd_pkg::FCD_IDLE;
                end
            end
            default: begin
                next_s.state = fcd_pkg::FCD_IDLE;
                next_s.command_complete_flag = fcd_pkg::COMPLETE_RST;
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.state <= fcd_pkg::FCD_IDLE;
            s.command_complete_flag <= fcd_pkg::COMPLETE_RST;
            s.access_error_flag <= fcd_pkg::FLAG_RST;
            s.fpviol <= fcd_pkg::FLAG_RST;
            s.div_loaded <= fcd_pkg::FLAG_RST;
            s.pf_user <= fcd_pkg::MARGIN_NORMAL;
            s.df_user <= fcd_pkg::MARGIN_NORMAL;
            s.pf_field <= fcd_pkg::MARGIN_NORMAL;
            s.df_field <= fcd_pkg::MARGIN_NORMAL;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign command_complete_flag_o = s.command_complete_flag;
    assign access_error_flag_o = s.access_error_flag;
    assign protect_violation_flag_o = s.fpviol;
    assign divider_loaded_flag_o = s.div_loaded;
    assign security_release_o = s.sec_release;
    assign op_start_o = s.op_start;
    assign op_code_o = s.code;
    assign op_target_dflash_o = s.target_df;
    assign op_word_count_o = s.words;
    assign pflash_user_margin_o = s.pf_user;
    assign dflash_user_margin_o = s.df_user;
    assign pflash_field_margin_o = s.pf_field;
    assign dflash_field_margin_o = s.df_field;

    // Pflash reads stay open during dflash-only writes unless margin reading
    assign pflash_read_ok_o = !s.pf_busy && !(s.df_write
        && (s.pf_user != fcd_pkg::MARGIN_NORMAL
        || s.pf_field != fcd_pkg::MARGIN_NORMAL));
    assign dflash_read_ok_o = !s.df_write && !(s.pf_busy && s.code != fcd_pkg::CMD_VERIFY_ALL
        && s.state != fcd_pkg::FCD_UNSEC_VERIFY) || !s.pf_busy && !s.df_write;

endmodule : fcd_top
